/* i2c_port_defs.svh */
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH

// Register addresses carried in the command byte.
`define REG_CHIP_IDENTITY     8'h00
`define REG_CHARGER_STATE     8'h01
`define REG_GENERAL_STATE     8'h02
`define REG_EVENT_ENABLE_MASK 8'h03
`define REG_CONTROL_BITS      8'h04
`define REG_CHARGE_CURRENT    8'h05
`define REG_CHARGE_VOLTAGE    8'h06
`define REG_SINK_CURRENT      8'h07
`define REG_SOFTWARE_RESET    8'h08
`define REG_NO_OPERATION      8'hFF

// Writable bit masks; reserved positions are held at zero.
`define MASK_EVENT_ENABLE     8'hFF
`define MASK_CONTROL_BITS     8'hDF
`define MASK_CHARGE_CURRENT   8'h1F
`define MASK_CHARGE_VOLTAGE   8'h1F
`define MASK_SINK_CURRENT     8'hFF
`define RW_RESET_VALUE        8'h00

// Field positions.
`define CTL_CHARGE_ENABLE_BIT 3
`define DIR_BIT               0
`define BYTE_LAST_BIT         3'h7
`define ACK_SLOT_BIT          4'h8

// Timing.
`define CLK_PERIOD_NS         100
`define SCL_PERIOD_NS         10000

`endif

/* i2c_port_pkg.sv */
package i2c_port_pkg;

  // Target end link states.
  typedef enum logic [2:0] {
    DEV_IDLE   = 3'b000,
    DEV_RX     = 3'b001,
    DEV_ACKW   = 3'b010,
    DEV_ACK    = 3'b011,
    DEV_TX     = 3'b100,
    DEV_MACK   = 3'b101,
    DEV_IGNORE = 3'b110
  } dev_state_t;

  // Controller end states.
  typedef enum logic [2:0] {
    HOST_IDLE   = 3'b000,
    HOST_START  = 3'b001,
    HOST_BIT    = 3'b010,
    HOST_RSTART = 3'b011,
    HOST_STOP   = 3'b100
  } host_state_t;

endpackage : i2c_port_pkg

/* i2c_link_if.sv */
`timescale 1ns/10ps
// Two-wire bus; the data wire is pulled up and only ever pulled low.
interface i2c_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND of both open-drain drivers over the pull-up.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport controller (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : i2c_link_if

/* pin_sync3.sv */
`timescale 1ns/10ps
// Three-stage synchroniser; the output moves only when stages two and three agree.
module pin_sync3 #(
  parameter int           W    = 1,  // Width.
  parameter logic [W-1:0] INIT = '0  // Reset value of every stage.
) (
  input  wire logic         i_clk, // Destination clock.
  input  wire logic         i_rst, // Destination synchronous reset.
  input  wire logic [W-1:0] i_d,   // Asynchronous input.
  output logic      [W-1:0] o_q    // Filtered output.
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  initial begin
    if (W < 1) $error("pin_sync3 needs W of at least one");
  end

  // Shift chain and agreement filter.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      o_q  <= INIT;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) o_q[i] <= s3_q[i];
      end
    end
  end

endmodule : pin_sync3

/* i2c_target_end.sv */
`timescale 1ns/10ps
`include "i2c_port_defs.svh"
// Notes on behaviour
// - Data falling while clock high starts frame.
// - Data rising while clock high ends frame.
// - Repeated start begins new frame, bus kept.
// - Target pulls data low through ninth clock.
// - Controller flags o_nack and sends stop when acknowledge is missing.
// - Controller acknowledges reads, not-acknowledges last byte.
// - Command byte after address selects register.
// - Data held, committed during its acknowledge.
// - Bytes are eight bits, MSB first, acknowledged.
// - Frames open with start, close with stop.
// - Write is address, register, one data byte.
// - Read uses repeated start, direction one.
// - Target drives data during read phase.
// - Address zero returns identity byte.
// - Address one returns charger status layout.
// - Charger active needs enable and bias.
// - Seven-bit address, one command, one data.
// - Clock is input; data only pulled low.
// - Controller changes data bits only while clock low; start and stop move data while clock high.
// - Boost alert edge-set, cleared by read.
module i2c_target_end
  import i2c_port_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR   = 7'h2C, // Bus address; value is arbitrary.
  parameter logic [7:0] CHIP_IDENTITY = 8'h5A  // Identity byte; value is arbitrary.
) (
  input  wire logic       i_clk,           // Core clock.
  input  wire logic       i_rst,           // Core synchronous reset, high.
  input  wire logic       i_link_clk,      // Link-side sampling clock.
  i2c_link_if.target      link,            // Two-wire bus.
  input  wire logic [2:0] i_charger_phase, // Charger phase code.
  input  wire logic [2:0] i_supply_flags,  // Under, over, headroom flags.
  input  wire logic       i_bias_ok,       // Bias above its undervoltage level.
  input  wire logic       i_boost_active,  // Boost is regulating.
  input  wire logic [5:0] i_gen_flags,     // Remaining general status bits.
  output logic      [7:0] o_event_mask,    // Event enable mask.
  output logic      [7:0] o_control,       // Control bits.
  output logic      [7:0] o_charge_current,// Charge current setting.
  output logic      [7:0] o_charge_voltage,// Charge voltage setting.
  output logic      [7:0] o_sink_current   // Sink current setting.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Crossings into the link domain.

  logic        link_rst;
  logic [1:0]  pins_f;
  logic [13:0] stat_s;
  logic        scl_f;
  logic        sda_f;

  // Reset is carried into the link domain as a level.
  pin_sync3 #(.W(1), .INIT(1'b1)) u_rst_sync (
    .i_clk (i_link_clk),
    .i_rst (1'b0),
    .i_d   (i_rst),
    .o_q   (link_rst)
  );

  // Bus pins; both idle high.
  pin_sync3 #(.W(2), .INIT(2'h3)) u_pin_sync (
    .i_clk (i_link_clk),
    .i_rst (link_rst),
    .i_d   ({link.scl, link.sda}),
    .o_q   (pins_f)
  );

  // Status levels from the core side.
  pin_sync3 #(.W(14), .INIT(14'h0000)) u_stat_sync (
    .i_clk (i_link_clk),
    .i_rst (link_rst),
    .i_d   ({i_charger_phase, i_supply_flags, i_bias_ok, i_boost_active, i_gen_flags}),
    .o_q   (stat_s)
  );

  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Link state.

  dev_state_t state_q;
  logic [1:0] pins_q;
  logic [2:0] cnt_q;
  logic [1:0] bi_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic [7:0] hold_q;
  logic       rw_q;
  logic       mack_q;
  logic       oe_q;
  logic [7:0] mask_q;
  logic [7:0] ctl_q;
  logic [7:0] cc_q;
  logic [7:0] cv_q;
  logic [7:0] sink_q;
  logic       alert_q;
  logic       boost_prev_q;
  logic       wr_tgl_q;

  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic       ack_c;
  logic       commit_c;
  logic       rd_load_c;
  logic [7:0] rd_addr_c;
  logic [7:0] rd_c;

  // Line events seen on the filtered pins.
  assign start_c = scl_f & pins_q[1] & pins_q[0] & ~sda_f;
  assign stop_c  = scl_f & pins_q[1] & ~pins_q[0] & sda_f;
  assign rise_c  = scl_f & ~pins_q[1];
  assign fall_c  = ~scl_f & pins_q[1];

  // Address byte must match; past the single data byte nothing is acknowledged.
  assign ack_c = (bi_q == 2'h0) ? (sh_q[7:1] == TARGET_ADDR) : (bi_q != 2'h3);

  // The held data byte lands on the rising edge of its acknowledge clock.
  assign commit_c = (state_q == DEV_ACK) & rise_c & oe_q & (bi_q == 2'h2);

  // A read byte is loaded on the falling edge that opens it.
  assign rd_load_c = fall_c & (((state_q == DEV_ACK) & oe_q & (bi_q == 2'h0) & rw_q) |
                               ((state_q == DEV_MACK) & mack_q));
  assign rd_addr_c = (state_q == DEV_MACK) ? ptr_q + 8'h01 : ptr_q;

  // Read multiplexer.
  always_comb begin
    case (rd_addr_c)
      `REG_CHIP_IDENTITY:     rd_c = CHIP_IDENTITY;
      `REG_CHARGER_STATE:     rd_c = {ctl_q[`CTL_CHARGE_ENABLE_BIT] & stat_s[7],
                                      stat_s[13:11], 1'b0, stat_s[10:8]};
      `REG_GENERAL_STATE:     rd_c = {stat_s[6], alert_q, stat_s[5:0]};
      `REG_EVENT_ENABLE_MASK: rd_c = mask_q;
      `REG_CONTROL_BITS:      rd_c = ctl_q;
      `REG_CHARGE_CURRENT:    rd_c = cc_q;
      `REG_CHARGE_VOLTAGE:    rd_c = cv_q;
      `REG_SINK_CURRENT:      rd_c = sink_q;
      default:                rd_c = 8'h00;
    endcase
  end

  // Previous pin levels for edge detection.
  always_ff @(posedge i_link_clk) begin
    if (link_rst) pins_q <= 2'h3;
    else pins_q <= pins_f;
  end

  // Byte engine: shifting, acknowledge and read-out.
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      state_q <= DEV_IDLE;
      cnt_q   <= 3'h0;
      bi_q    <= 2'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      hold_q  <= 8'h00;
      rw_q    <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (start_c) begin
      state_q <= DEV_RX;
      cnt_q   <= 3'h0;
      bi_q    <= 2'h0;
      oe_q    <= 1'b0;
    end else if (stop_c) begin
      state_q <= DEV_IDLE;
      oe_q    <= 1'b0;
    end else begin
      case (state_q)
        DEV_RX: begin
          if (rise_c) begin
            sh_q  <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `BYTE_LAST_BIT) state_q <= DEV_ACKW;
          end
        end
        DEV_ACKW: begin
          if (fall_c) begin
            oe_q    <= ack_c;
            state_q <= DEV_ACK;
            if (bi_q == 2'h0) rw_q <= sh_q[`DIR_BIT];
            if (bi_q == 2'h1) ptr_q <= sh_q;
            if (bi_q == 2'h2) hold_q <= sh_q;
          end
        end
        DEV_ACK: begin
          if (fall_c) begin
            bi_q  <= (bi_q == 2'h3) ? bi_q : bi_q + 2'h1;
            cnt_q <= 3'h0;
            if (!oe_q) begin
              state_q <= DEV_IGNORE;
            end else if (rd_load_c) begin
              sh_q    <= rd_c;
              oe_q    <= ~rd_c[7];
              state_q <= DEV_TX;
            end else begin
              oe_q    <= 1'b0;
              state_q <= DEV_RX;
            end
          end
        end
        DEV_TX: begin
          if (rise_c) cnt_q <= cnt_q + 3'h1;
          if (fall_c) begin
            if (cnt_q == 3'h0) begin
              oe_q    <= 1'b0;
              state_q <= DEV_MACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
        end
        DEV_MACK: begin
          if (rise_c) mack_q <= ~sda_f;
          if (fall_c) begin
            if (mack_q) begin
              ptr_q   <= rd_addr_c;
              sh_q    <= rd_c;
              oe_q    <= ~rd_c[7];
              state_q <= DEV_TX;
            end else begin
              state_q <= DEV_IGNORE;
            end
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Writable registers; read-only, no-operation and unmapped targets change nothing; software reset clears all five.
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      mask_q <= `RW_RESET_VALUE;
      ctl_q  <= `RW_RESET_VALUE;
      cc_q   <= `RW_RESET_VALUE;
      cv_q   <= `RW_RESET_VALUE;
      sink_q <= `RW_RESET_VALUE;
    end else if (commit_c) begin
      case (ptr_q)
        `REG_EVENT_ENABLE_MASK: mask_q <= hold_q & `MASK_EVENT_ENABLE;
        `REG_CONTROL_BITS:      ctl_q  <= hold_q & `MASK_CONTROL_BITS;
        `REG_CHARGE_CURRENT:    cc_q   <= hold_q & `MASK_CHARGE_CURRENT;
        `REG_CHARGE_VOLTAGE:    cv_q   <= hold_q & `MASK_CHARGE_VOLTAGE;
        `REG_SINK_CURRENT:      sink_q <= hold_q & `MASK_SINK_CURRENT;
        `REG_SOFTWARE_RESET: begin
          mask_q <= `RW_RESET_VALUE;
          ctl_q  <= `RW_RESET_VALUE;
          cc_q   <= `RW_RESET_VALUE;
          cv_q   <= `RW_RESET_VALUE;
          sink_q <= `RW_RESET_VALUE;
        end
        default: begin
          mask_q <= mask_q;
        end
      endcase
    end
  end

  // Boost alert: set on activation edge, cleared by a read; setting wins.
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      boost_prev_q <= 1'b0;
      alert_q      <= 1'b0;
    end else begin
      boost_prev_q <= stat_s[6];
      if (stat_s[6] & ~boost_prev_q) alert_q <= 1'b1;
      else if (rd_load_c & (rd_addr_c == `REG_GENERAL_STATE)) alert_q <= 1'b0;
    end
  end

  // Each committed write flips a toggle that tells the core side to copy.
  always_ff @(posedge i_link_clk) begin
    if (link_rst) wr_tgl_q <= 1'b0;
    else if (commit_c) wr_tgl_q <= ~wr_tgl_q;
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Core side copy of the settings.

  logic tgl_s;
  logic tgl_prev_q;

  pin_sync3 #(.W(1), .INIT(1'b0)) u_tgl_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (wr_tgl_q),
    .o_q   (tgl_s)
  );

  // Settings are stable long before the toggle arrives, so a word copy is safe.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tgl_prev_q       <= 1'b0;
      o_event_mask     <= `RW_RESET_VALUE;
      o_control        <= `RW_RESET_VALUE;
      o_charge_current <= `RW_RESET_VALUE;
      o_charge_voltage <= `RW_RESET_VALUE;
      o_sink_current   <= `RW_RESET_VALUE;
    end else begin
      tgl_prev_q <= tgl_s;
      if (tgl_s != tgl_prev_q) begin
        o_event_mask     <= mask_q;
        o_control        <= ctl_q;
        o_charge_current <= cc_q;
        o_charge_voltage <= cv_q;
        o_sink_current   <= sink_q;
      end
    end
  end

endmodule : i2c_target_end

/* i2c_controller_end.sv */
`timescale 1ns/10ps
`include "i2c_port_defs.svh"
// Bus controller: single-byte register write or combined-format read.
module i2c_controller_end
  import i2c_port_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR    = 7'h2C, // Target bus address.
  parameter int         QUARTER_CYCLES = `SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS) // Quarter bit.
) (
  input  wire logic       i_clk,      // Core clock.
  input  wire logic       i_rst,      // Synchronous reset, high.
  i2c_link_if.controller  link,       // Two-wire bus.
  input  wire logic       i_req,      // Start a transfer, pulse.
  input  wire logic       i_read,     // One for read, zero for write.
  input  wire logic [7:0] i_reg_addr, // Register address.
  input  wire logic [7:0] i_wr_data,  // Write data.
  output logic            o_busy,     // Transfer in progress.
  output logic            o_done,     // Transfer finished, pulse.
  output logic            o_nack,     // Last transfer lacked an acknowledge.
  output logic      [7:0] o_rd_data   // Last byte read.
);

  host_state_t state_q;
  logic [15:0] tick_cnt_q;
  logic        tick_c;
  logic [1:0]  q_q;
  logic [3:0]  bit_q;
  logic [2:0]  seq_q;
  logic [7:0]  tx_q;
  logic [7:0]  rx_q;
  logic        ack_bit_q;
  logic        read_q;
  logic [7:0]  reg_q;
  logic [7:0]  data_q;
  logic        scl_q;
  logic        oe_q;
  logic        sda_s;

  initial begin
    if (QUARTER_CYCLES < 1 || QUARTER_CYCLES > 65535) $error("QUARTER_CYCLES out of range");
  end

  // Data line seen through the pin synchroniser.
  pin_sync3 #(.W(1), .INIT(1'b1)) u_sda_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (link.sda),
    .o_q   (sda_s)
  );

  // Quarter-bit divider that paces the bus clock.
  always_ff @(posedge i_clk) begin
    if (i_rst || tick_c) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick_cnt_q + 16'h0001;
  end
  assign tick_c = (tick_cnt_q == 16'(QUARTER_CYCLES - 1));

  // Frame sequencer; data bits change only in quarter zero while the clock is low; start and stop move data in quarter two.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= HOST_IDLE;
      q_q       <= 2'h0;
      bit_q     <= 4'h0;
      seq_q     <= 3'h0;
      tx_q      <= 8'h00;
      rx_q      <= 8'h00;
      ack_bit_q <= 1'b1;
      read_q    <= 1'b0;
      reg_q     <= 8'h00;
      data_q    <= 8'h00;
      scl_q     <= 1'b1;
      oe_q      <= 1'b0;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_nack    <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (state_q == HOST_IDLE) begin
        if (i_req) begin
          state_q <= HOST_START;
          q_q     <= 2'h0;
          seq_q   <= 3'h0;
          read_q  <= i_read;
          reg_q   <= i_reg_addr;
          data_q  <= i_wr_data;
          tx_q    <= {TARGET_ADDR, 1'b0};
          o_busy  <= 1'b1;
          o_nack  <= 1'b0;
        end
      end else if (tick_c) begin
        q_q <= q_q + 2'h1;
        case (state_q)
          HOST_START, HOST_RSTART: begin
            case (q_q)
              2'h0: oe_q <= 1'b0;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b1;
              default: begin
                scl_q   <= 1'b0;
                bit_q   <= 4'h0;
                state_q <= HOST_BIT;
              end
            endcase
          end
          HOST_BIT: begin
            case (q_q)
              2'h0: oe_q <= (bit_q == `ACK_SLOT_BIT) ? 1'b0 : ~tx_q[7];
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q == `ACK_SLOT_BIT) ack_bit_q <= sda_s;
                else rx_q <= {rx_q[6:0], sda_s};
              end
              default: begin
                scl_q <= 1'b0;
                tx_q  <= {tx_q[6:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == `ACK_SLOT_BIT) begin
                  bit_q <= 4'h0;
                  seq_q <= seq_q + 3'h1;
                  if (seq_q != 3'h4 && ack_bit_q) begin
                    o_nack  <= 1'b1;
                    state_q <= HOST_STOP;
                  end else if (seq_q == 3'h0) begin
                    tx_q <= reg_q;
                  end else if (seq_q == 3'h1) begin
                    tx_q <= data_q;
                    if (read_q) begin
                      tx_q    <= {TARGET_ADDR, 1'b1};
                      seq_q   <= 3'h3;
                      state_q <= HOST_RSTART;
                    end
                  end else if (seq_q == 3'h3) begin
                    tx_q <= 8'hFF;
                  end else begin
                    if (seq_q == 3'h4) o_rd_data <= rx_q;
                    state_q <= HOST_STOP;
                  end
                end
              end
            endcase
          end
          HOST_STOP: begin
            case (q_q)
              2'h0: oe_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: oe_q <= 1'b0;
              default: begin
                state_q <= HOST_IDLE;
                o_busy  <= 1'b0;
                o_done  <= 1'b1;
              end
            endcase
          end
          default: state_q <= HOST_IDLE;
        endcase
      end
    end
  end

  assign link.scl         = scl_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = oe_q;

endmodule : i2c_controller_end

/* i2c_link_properties.sv */
`timescale 1ns/10ps
// Watches the two-wire bus between the controller end and the target end.
module i2c_link_properties (
  input wire logic i_clk,       // Core clock.
  input wire logic i_rst,       // Core reset, high.
  input wire logic scl,         // Bus clock.
  input wire logic sda,         // Resolved data.
  input wire logic host_sda_o,  // Controller data level.
  input wire logic host_sda_oe, // Controller pull-low.
  input wire logic dev_sda_o,   // Target data level.
  input wire logic dev_sda_oe   // Target pull-low.
);
  logic       scl_q;
  logic       sda_q;
  logic [5:0] rise_cnt_q;
  logic       start_ev;
  logic       stop_ev;
  logic       legal_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Start and stop are data edges while the clock stays high.
  assign start_ev  = scl & scl_q & sda_q & ~sda;
  assign stop_ev   = scl & scl_q & ~sda_q & sda;
  // A frame closes after whole bytes plus the closing clock rise.
  assign legal_cnt = (rise_cnt_q == 6'h0A) | (rise_cnt_q == 6'h13) | (rise_cnt_q == 6'h1C);

  // Keeps the bus levels of the previous cycle.
  always_ff @(posedge i_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // Counts clock rises since the latest start.
  always_ff @(posedge i_clk) begin
    if (i_rst || start_ev) begin
      rise_cnt_q <= 6'h00;
    end else if (scl && !scl_q) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_pins_pull_only: assert property (!dev_sda_o && !host_sda_o)
    else $error("data pin driven high");
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("target data moved while clock high");
  a_start_then_low: assert property (start_ev |-> ##[1:8] !scl)
    else $error("clock not lowered after start");
  a_stop_frees_bus: assert property (stop_ev |-> scl [*8])
    else $error("clock moved right after stop");
  a_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_low_span: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("clock low phase too short");
  a_frame_open: assert property (start_ev |-> legal_cnt || rise_cnt_q == 6'h00)
    else $error("start after partial byte");
  a_frame_close: assert property (stop_ev |-> legal_cnt)
    else $error("stop after partial byte");
endmodule : i2c_link_properties

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] ID = 8'h3C; // Arbitrary identity value.
  logic       i_clk, i_rst, i_link_clk, req, rd, bias, boost, busy, done, nack;
  logic [2:0] phase, sup;
  logic [5:0] gen;
  logic [7:0] ra, wd, rdat, mask, ctl, cc, cv, sk;
  int         error_cnt;
  int         check_count;

  i2c_link_if link ();

  i2c_target_end #(.CHIP_IDENTITY(ID)) u_i2c_target_end (
    .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .link(link),
    .i_charger_phase(phase), .i_supply_flags(sup), .i_bias_ok(bias),
    .i_boost_active(boost), .i_gen_flags(gen), .o_event_mask(mask),
    .o_control(ctl), .o_charge_current(cc), .o_charge_voltage(cv),
    .o_sink_current(sk));

  i2c_controller_end #(.QUARTER_CYCLES(4)) u_i2c_controller_end (
    .i_clk(i_clk), .i_rst(i_rst), .link(link), .i_req(req), .i_read(rd),
    .i_reg_addr(ra), .i_wr_data(wd), .o_busy(busy), .o_done(done),
    .o_nack(nack), .o_rd_data(rdat));

  i2c_link_properties u_i2c_link_properties (
    .i_clk(i_clk), .i_rst(i_rst), .scl(link.scl), .sda(link.sda),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe));

  //////////////////////////////////////////////////////////////////////////////
  // Core clock and a link clock of unrelated phase.
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'h0;
    #3.7;
    forever #7.5 i_link_clk = ~i_link_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compares one byte and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Runs one transfer and waits a bounded time for its end.
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(negedge i_clk);
    req = 1'h1;
    rd = r;
    ra = a;
    wd = d;
    @(negedge i_clk);
    req = 1'h0;
    chk({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'h1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, nack}, 8'h00);
    repeat (6) @(negedge i_clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'h0, a, d);
  endtask : wr

  task automatic rdv(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'h1, a, 8'h00);
    chk(rdat, exp);
  endtask : rdv

  // Checks all five setting outputs at once.
  task automatic outs(input logic [39:0] e);
    chk(mask, e[39:32]);
    chk(ctl, e[31:24]);
    chk(cc, e[23:16]);
    chk(cv, e[15:8]);
    chk(sk, e[7:0]);
  endtask : outs

  //////////////////////////////////////////////////////////////////////////////
  // Writes every setting register; reserved bits must stay clear.
  task automatic t_rw;
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hFF);
    wr(8'h06, 8'hFF);
    wr(8'h07, 8'h5A);
    outs(40'hFF_DF_1F_1F_5A);
    rdv(8'h04, 8'hDF);
    rdv(8'h05, 8'h1F);
    rdv(8'h07, 8'h5A);
  endtask : t_rw

  // Writes to read-only or unmapped places change nothing.
  task automatic t_ro;
    wr(8'h00, 8'hFF);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    wr(8'h10, 8'h00);
    outs(40'hFF_DF_1F_1F_5A);
    rdv(8'h00, ID);
    rdv(8'h10, 8'h00);
    rdv(8'h08, 8'h00);
    rdv(8'hFF, 8'h00);
  endtask : t_ro

  // Charger status layout and the active flag condition.
  task automatic t_status;
    phase = 3'h6;
    sup = 3'h5;
    bias = 1'h1;
    rdv(8'h01, 8'hE5);
    bias = 1'h0;
    rdv(8'h01, 8'h65);
    bias = 1'h1;
    wr(8'h04, 8'h00);
    rdv(8'h01, 8'h65);
  endtask : t_status

  // Boost alert is edge set and cleared by a read.
  task automatic t_alert;
    gen = 6'h2A;
    boost = 1'h1;
    rdv(8'h02, 8'hEA);
    rdv(8'h02, 8'hAA);
    boost = 1'h0;
    rdv(8'h02, 8'h2A);
    boost = 1'h1;
    rdv(8'h02, 8'hEA);
  endtask : t_alert

  // No-operation leaves settings; software reset clears them.
  task automatic t_swrst;
    wr(8'hFF, 8'h12);
    outs(40'hFF_00_1F_1F_5A);
    wr(8'h08, 8'h00);
    outs(40'h00);
  endtask : t_swrst

  // A reset in mid-run returns every setting and the read data to zero.
  task automatic t_reset;
    wr(8'h06, 8'h0C);
    outs(40'h00_00_00_0C_00);
    i_rst = 1'h1;
    repeat (20) @(negedge i_clk);
    outs(40'h00);
    chk(rdat, 8'h00);
    i_rst = 1'h0;
    repeat (10) @(negedge i_clk);
    rdv(8'h06, 8'h00);
  endtask : t_reset

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // The sequence needs about 16k cycles; cut it off well beyond that.
  initial begin
    #5_000_000;
    error_cnt++;
    stop_test();
  end

  // Resets both ends, then runs the scenarios in turn.
  initial begin
    error_cnt = 0;
    check_count = 0;
    i_rst = 1'h1;
    {req, rd, bias, boost} = 4'h0;
    {phase, sup, gen} = 12'h000;
    {ra, wd} = 16'h0000;
    repeat (20) @(negedge i_clk);
    outs(40'h00);
    i_rst = 1'h0;
    repeat (10) @(negedge i_clk);
    t_rw();
    t_ro();
    t_status();
    t_alert();
    t_swrst();
    t_reset();
    stop_test();
  end
endmodule : testbench
